// ### rtl/fpm_param_bank.sv
// Fieldbus process-data mapping parameter bank with its mapping logic.
// Assumes requests, process data and drive status share clk; the NV store
// outside hands back a saved image by restore after power-up.
//
// Contract
// RULE1: Mapping word: low half index, high subindex
// RULE2: Output mapping routes words five/six; default acceleration
// RULE3: Output zero disables; digital-output code routes outputs
// RULE4: Input mapping fills words five/six; default none
// RULE5: Input accepts error, I/O, temperature, supply, current
// RULE6: Pending static read refreshed each programmed millisecond period
// RULE7: Master clear: 0 nothing, 1 class-2 fault if enabled
// RULE8: Master rewrites non-default parameters at each startup
// RULE9: Out-of-range write refused with range error code
// RULE10: Parameters retained and read back unchanged
`timescale 1ns/1ps
`default_nettype none
module fpm_param_bank
  import fpm_pkg::*;
#(
  parameter int unsigned MS_CNT = MS_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire fpm_req_t    req,          // Parameter channel request
  output fpm_rsp_t         rsp,          // Parameter channel answer
  input  wire logic        restore,      // Load saved image
  input  wire fpm_params_t restoreImage, // Saved image from NV store
  output fpm_params_t      params,       // Image to be saved
  input  wire logic        rxValid,      // Words five/six received
  input  wire logic [31:0] rxWords,      // Words five/six from master
  output fpm_objwr_t       objWrite,     // Routed object write
  input  wire fpm_src_t    src,          // Drive objects
  output logic [31:0]      txWords,      // Words five/six to master
  input  wire logic        readPending,  // Static read job pending
  output logic             readRefresh,  // Refresh the read value
  input  wire logic        masterClear,  // Master in Clear state
  input  wire logic        ampEnabled,   // Power amplifier enabled
  output logic             faultReq,     // Request fault state
  output logic [1:0]       faultClass    // Class of the raised error
);

  fpm_params_t parQ, parD;      // Parameter store
  fpm_rsp_t    rspQ, rspD;      // Answer register
  fpm_objwr_t  owQ,  owD;       // Object write register
  logic [31:0] txQ,  txD;       // Outgoing words
  logic        clrQ, clrD;      // Previous master clear level
  logic        fltQ, fltD;      // Fault pulse
  logic [1:0]  clsQ, clsD;      // Fault class held after a fault
  logic        tick;            // Refresh pulse from the timer

  // Range check of a write value for each member of the group
  function automatic logic inRange(input logic [7:0] sub,
                                   input logic [31:0] v);
    logic ok;
    ok = 1'b0;
    case (sub)
      SUB_MAP_OUT: ok = (v == MAP_NONE) || (v == MAP_ACCEL) ||
                        (v == MAP_DIGIO); // [RULE3]
      SUB_MAP_IN:  ok = (v == MAP_NONE) || (v == MAP_ERRNUM) ||
                        (v == MAP_DIGIO) || (v == MAP_AMPTEMP) ||
                        (v == MAP_SUPPLY) || (v == MAP_CURRENT); // [RULE5]
      SUB_REFRESH: ok = (v >= REFRESH_MIN) && (v <= REFRESH_MAX);
      SUB_CLEAR:   ok = (v <= CLEAR_MAX);
      default:     ok = 1'b0;
    endcase
    return ok;
  endfunction

  // Parameter channel: decode, range check, store and answer next cycle
  always_comb begin
    parD = parQ;
    rspD = '0;
    if (restore) begin
      parD = restoreImage; // [RULE10]
    end
    // A write in the same cycle as restore overrides that one member
    if (req.valid) begin
      rspD.valid = 1'b1;
      if (req.index != GROUP_INDEX) begin
        // Only this group lives here; other objects answer unknown
        rspD.error = 1'b1;
        rspD.data  = ERR_NO_OBJ;
      end else if (req.subindex < SUB_MAP_OUT ||
                   req.subindex > SUB_CLEAR) begin
        rspD.error = 1'b1;
        rspD.data  = ERR_NO_SUB;
      end else if (req.write) begin
        if (!inRange(req.subindex, req.data)) begin
          // Stored value is left untouched on a refused write
          rspD.error = 1'b1; // [RULE9]
          rspD.data  = ERR_RANGE; // [RULE9]
        end else begin
          rspD.data = req.data;
          case (req.subindex)
            SUB_MAP_OUT: parD.output_object_mapping  = req.data;
            SUB_MAP_IN:  parD.input_object_mapping   = req.data;
            SUB_REFRESH: parD.refresh = req.data;
            default:     parD.clear   = req.data;
          endcase
        end
      end else begin
        // Read back returns the stored word as written
        case (req.subindex)
          SUB_MAP_OUT: rspD.data = parQ.output_object_mapping; // [RULE10]
          SUB_MAP_IN:  rspD.data = parQ.input_object_mapping;
          SUB_REFRESH: rspD.data = parQ.refresh;
          default:     rspD.data = parQ.clear;
        endcase
      end
    end
  end

  // Output direction: received words go to the mapped drive object
  always_comb begin
    owD = '0;
    if (rxValid && parQ.output_object_mapping != MAP_NONE) begin // [RULE3]
      owD.valid    = 1'b1; // [RULE2]
      owD.index    = parQ.output_object_mapping[MAP_IDX_LSB +: 16]; // [RULE1]
      owD.subindex = parQ.output_object_mapping[MAP_SUB_LSB +: 16]; // [RULE1]
      owD.data     = rxWords;
    end
  end

  // Input direction: selected drive object goes to the master
  always_comb begin
    case (parQ.input_object_mapping) // [RULE4]
      MAP_ERRNUM:  txD = src.errorNumber; // [RULE5]
      MAP_DIGIO:   txD = src.digitalIo;
      MAP_AMPTEMP: txD = src.ampTemp;
      MAP_SUPPLY:  txD = src.supplyVolt;
      MAP_CURRENT: txD = src.motorCurrent;
      default:     txD = 32'h0000_0000;
    endcase
  end

  // Master clear: react once on entry into the Clear state
  always_comb begin
    clrD = masterClear;
    fltD = 1'b0;
    clsD = clsQ;
    if (masterClear && !clrQ && parQ.clear == CLEAR_FAULT &&
        ampEnabled) begin
      fltD = 1'b1; // [RULE7]
      clsD = CLEAR_CLASS; // [RULE7]
    end
  end

  // Parameter store; reset loads the power-up defaults. The saved image
  // only comes back through restore, so a bare reset drops user values
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      parQ.output_object_mapping  <= RST_MAP_OUT; // [RULE2]
      parQ.input_object_mapping   <= RST_MAP_IN; // [RULE4]
      parQ.refresh <= RST_REFRESH; // [RULE6]
      parQ.clear   <= RST_CLEAR; // [RULE7]
    end else begin
      parQ <= parD;
    end
  end

  // Channel answer register; each answer stands for one cycle
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rspQ <= '0;
    end else begin
      rspQ <= rspD;
    end
  end

  // Routed object write register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      owQ <= '0;
    end else begin
      owQ <= owD;
    end
  end

  // Outgoing words; one cycle behind a mapping or source change
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      txQ <= 32'h0000_0000;
    end else begin
      txQ <= txD;
    end
  end

  // Clear level history, fault pulse and the class left visible
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      clrQ <= 1'b0;
      fltQ <= 1'b0;
      clsQ <= 2'h0;
    end else begin
      clrQ <= clrD;
      fltQ <= fltD;
      clsQ <= clsD;
    end
  end

  // Refresh timer; the period is range checked so 16 bits suffice
  fpm_refresh_timer #(
    .MS_CNT   (MS_CNT)
  ) u_timer (
    .clk      (clk),
    .rst      (rst),
    .run      (readPending),
    .periodMs (parQ.refresh[15:0]),
    .tick     (tick)
  );

  // Refresh pulse is already registered inside the timer
  assign readRefresh = tick; // [RULE6]
  assign rsp         = rspQ;
  assign params      = parQ;
  assign objWrite    = owQ;
  assign txWords     = txQ;
  assign faultReq    = fltQ;
  assign faultClass  = clsQ;

endmodule
`default_nettype wire

// ### rtl/fpm_pkg.sv
// Constants, object codes and carrier types of the fieldbus mapping bank.
// Assumes a single 40 MHz clock shared by the bank and the parameter channel.
package fpm_pkg;

  // Clock rate and the millisecond base used by the refresh timer
  localparam int unsigned CLK_HZ        = 40_000_000;
  localparam int unsigned MS_PER_S      = 1000;
  localparam int unsigned MS_CYCLES     = CLK_HZ / MS_PER_S;

  // Object address of the parameter group and its four members
  localparam logic [15:0] GROUP_INDEX   = 16'h0018;
  localparam logic [7:0]  SUB_MAP_OUT   = 8'h02;
  localparam logic [7:0]  SUB_MAP_IN    = 8'h03;
  localparam logic [7:0]  SUB_REFRESH   = 8'h04;
  localparam logic [7:0]  SUB_CLEAR     = 8'h05;

  // Mapping field layout: low half index, high half subindex
  localparam int unsigned MAP_IDX_LSB   = 0;
  localparam int unsigned MAP_SUB_LSB   = 16;

  // Mapping selection codes
  localparam logic [31:0] MAP_NONE      = 32'h0000_0000;
  localparam logic [31:0] MAP_ACCEL     = 32'h001a_001d;
  localparam logic [31:0] MAP_DIGIO     = 32'h0001_0021;
  localparam logic [31:0] MAP_ERRNUM    = 32'h0007_0020;
  localparam logic [31:0] MAP_AMPTEMP   = 32'h0019_001f;
  localparam logic [31:0] MAP_SUPPLY    = 32'h0014_001f;
  localparam logic [31:0] MAP_CURRENT   = 32'h000c_001f;

  // Reset values
  localparam logic [31:0] RST_MAP_OUT   = MAP_ACCEL;
  localparam logic [31:0] RST_MAP_IN    = MAP_NONE;
  localparam logic [31:0] RST_REFRESH   = 32'h0000_03e8;
  localparam logic [31:0] RST_CLEAR     = 32'h0000_0001;

  // Permitted ranges
  localparam logic [31:0] REFRESH_MIN   = 32'h0000_0001;
  localparam logic [31:0] REFRESH_MAX   = 32'h0000_ea60;
  localparam logic [31:0] CLEAR_MAX     = 32'h0000_0001;
  localparam logic [31:0] CLEAR_FAULT   = 32'h0000_0001;
  localparam logic [15:0] PERIOD_W_MAX  = 16'hea60;

  // Error codes returned on the parameter channel
  localparam logic [31:0] ERR_RANGE     = 32'h0609_0030;
  localparam logic [31:0] ERR_NO_SUB    = 32'h0609_0011;
  localparam logic [31:0] ERR_NO_OBJ    = 32'h0602_0000;

  // Error class raised on master clear
  localparam logic [1:0]  CLEAR_CLASS   = 2'h2;

  // Parameter channel request
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [7:0]  subindex;
    logic [31:0] data;
  } fpm_req_t;

  // Parameter channel answer
  typedef struct packed {
    logic        valid;
    logic        error;
    logic [31:0] data;
  } fpm_rsp_t;

  // Drive objects that may be sent to the master
  typedef struct packed {
    logic [31:0] errorNumber;
    logic [31:0] digitalIo;
    logic [31:0] ampTemp;
    logic [31:0] supplyVolt;
    logic [31:0] motorCurrent;
  } fpm_src_t;

  // Object write toward the drive
  typedef struct packed {
    logic        valid;
    logic [15:0] index;
    logic [15:0] subindex;
    logic [31:0] data;
  } fpm_objwr_t;

  // Stored parameter image
  typedef struct packed {
    logic [31:0] output_object_mapping;
    logic [31:0] input_object_mapping;
    logic [31:0] refresh;
    logic [31:0] clear;
  } fpm_params_t;

endpackage

// ### rtl/fpm_refresh_timer.sv
// Millisecond period timer for a pending static read job.
// Assumes period is already range checked and stable between ticks.
`timescale 1ns/1ps
`default_nettype none
module fpm_refresh_timer
  import fpm_pkg::*;
#(
  parameter int unsigned MS_CNT = MS_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic [15:0] periodMs,
  output logic             tick
);

  logic [15:0] preQ, preD;   // Cycles inside one millisecond
  logic [15:0] msQ,  msD;    // Milliseconds elapsed in the period
  logic        tickQ, tickD; // Refresh pulse

  localparam logic [15:0] PRE_LAST = 16'(MS_CNT - 1);

  // Next state: both counters hold at zero while no job is pending
  always_comb begin
    preD  = preQ;
    msD   = msQ;
    tickD = 1'b0;
    if (!run) begin
      preD = 16'h0000;
      msD  = 16'h0000;
    end else if (preQ == PRE_LAST) begin
      preD = 16'h0000;
      // A shortened period takes effect at the next millisecond
      if (msQ + 16'h0001 >= periodMs) begin
        msD   = 16'h0000;
        tickD = 1'b1; // [RULE6]
      end else begin
        msD = msQ + 16'h0001;
      end
    end else begin
      preD = preQ + 16'h0001;
    end
  end

  // Registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      preQ  <= 16'h0000;
      msQ   <= 16'h0000;
      tickQ <= 1'b0;
    end else begin
      preQ  <= preD;
      msQ   <= msD;
      tickQ <= tickD;
    end
  end

  assign tick = tickQ;

endmodule
`default_nettype wire

// ### verification/fpm_checker.sv
// Port assertions for the mapping parameter bank.
// Assumes one clock domain; bound into every bank instance.
`timescale 1ns/1ps
`default_nettype none
module fpm_checker
  import fpm_pkg::*;
#(
  parameter int unsigned MS_CNT = MS_CYCLES
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire fpm_req_t    req,
  input wire fpm_rsp_t    rsp,
  input wire fpm_params_t params,
  input wire logic        rxValid,
  input wire logic [31:0] rxWords,
  input wire fpm_objwr_t  objWrite,
  input wire fpm_src_t    src,
  input wire logic [31:0] txWords,
  input wire logic        readPending,
  input wire logic        readRefresh,
  input wire logic        masterClear,
  input wire logic        ampEnabled,
  input wire logic        faultReq,
  input wire logic [1:0]  faultClass
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic [31:0] pendCnt_q; // Cycles spent with a read pending
  logic [31:0] pendCnt_d;
  logic [31:0] per;       // Refresh period in clock cycles
  // Counter restarts whenever the job is dropped
  always_comb begin
    pendCnt_d = readPending ? pendCnt_q + 32'h1 : 32'h0;
    per       = params.refresh * MS_CNT;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pendCnt_q <= 32'h0;
    end else begin
      pendCnt_q <= pendCnt_d;
    end
  end
  // Entry into Clear with the fault reaction armed
  sequence s_clear_entry;
    masterClear && !$past(masterClear) && ampEnabled
      && params.clear == CLEAR_FAULT;
  endsequence
  a_rsp_latency: assert property (req.valid |=> rsp.valid)
    else $error("answer missing one cycle after request");
  a_range_refuse: assert property (req.valid && req.write
    && req.index == GROUP_INDEX && req.subindex == SUB_CLEAR
    && req.data > CLEAR_MAX |=> rsp.error && rsp.data == ERR_RANGE
    && $stable(params.clear)) else $error("out of range write taken");
  a_obj_route: assert property (rxValid && params.output_object_mapping != MAP_NONE
    |=> objWrite.valid && objWrite.data == $past(rxWords)
    && {objWrite.subindex, objWrite.index} == $past(params.output_object_mapping))
    else $error("object write wrong");
  a_obj_off: assert property (!(rxValid && params.output_object_mapping != MAP_NONE)
    |=> !objWrite.valid) else $error("object write while disabled");
  a_tx_none: assert property (params.input_object_mapping == MAP_NONE
    |=> txWords == 32'h0) else $error("words sent without mapping");
  a_tx_current: assert property (params.input_object_mapping == MAP_CURRENT
    |=> txWords == $past(src.motorCurrent)) else $error("current not sent");
  a_fault_raise: assert property (s_clear_entry
    |=> faultReq && faultClass == CLEAR_CLASS) else $error("no fault");
  a_fault_quiet: assert property (!(masterClear
    && !$past(masterClear) && ampEnabled && params.clear == CLEAR_FAULT)
    |=> !faultReq)
    else $error("fault without cause");
  a_refresh_grid: assert property (readPending |-> readRefresh ==
    (pendCnt_q != 32'h0 && pendCnt_q % per == 32'h0))
    else $error("refresh off its period");
endmodule
bind fpm_param_bank fpm_checker #(.MS_CNT(MS_CNT)) u_chk (.clk(clk),
  .rst(rst), .req(req), .rsp(rsp), .params(params), .rxValid(rxValid),
  .rxWords(rxWords), .objWrite(objWrite), .src(src), .txWords(txWords),
  .readPending(readPending), .readRefresh(readRefresh),
  .masterClear(masterClear), .ampEnabled(ampEnabled),
  .faultReq(faultReq), .faultClass(faultClass));
`default_nettype wire

// ### verification/fpm_master_model.sv
// Behavioural fieldbus master: process-data words and the Clear state.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module fpm_master_model (
  output logic        rxValid,
  output logic [31:0] rxWords,
  output logic        masterClear,
  input  wire logic   clk
);
  initial begin
    rxValid = 1'b0;
    rxWords = 32'h0;
    masterClear = 1'b0;
  end
  // Words are inverted once stale so old data never passes as fresh
  task automatic sendWords(input logic [31:0] w);
    rxWords = w;
    rxValid = 1'b1;
    @(posedge clk);
    #1;
    rxValid = 1'b0;
    rxWords = ~w;
  endtask
  // Master enters or leaves its Clear state
  task automatic setClear(input logic c);
    masterClear = c;
  endtask
endmodule
`default_nettype wire

// ### verification/tb_fieldbus_pdo_mapping_params.sv
// Self-checking bench for the mapping parameter bank.
// Assumes the master model and checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module tb_fieldbus_pdo_mapping_params;
  import fpm_pkg::*;
  localparam int unsigned MS = 4; // Short millisecond keeps the run brief
  localparam logic [31:0] IN_CODE [5] =
    '{MAP_ERRNUM, MAP_DIGIO, MAP_AMPTEMP, MAP_SUPPLY, MAP_CURRENT};
  logic clk = 1'b0, rst = 1'b1, restore = 1'b0;
  logic readPending = 1'b0, ampEnabled = 1'b0;
  logic rxValid, masterClear, readRefresh, faultReq;
  logic [31:0] rxWords, txWords;
  logic [1:0] faultClass;
  logic [33:0] got; // Last answer: valid, error, data
  fpm_req_t req = '0;
  fpm_rsp_t rsp;
  fpm_params_t img = '0, params;
  fpm_objwr_t objWrite;
  fpm_src_t src = {32'he01, 32'hd02, 32'hc03, 32'hb04, 32'ha05};
  int n_fail = 0, checks = 0, cyc = 0, n;
  always #12.5 clk = ~clk;
  fpm_master_model u_master (.clk(clk), .rxValid(rxValid),
    .rxWords(rxWords), .masterClear(masterClear));
  fpm_param_bank #(.MS_CNT(MS)) u_dut (.clk(clk), .rst(rst), .req(req),
    .rsp(rsp), .restore(restore), .restoreImage(img), .params(params),
    .rxValid(rxValid), .rxWords(rxWords), .objWrite(objWrite), .src(src),
    .txWords(txWords), .readPending(readPending), .readRefresh(readRefresh),
    .masterClear(masterClear), .ampEnabled(ampEnabled),
    .faultReq(faultReq), .faultClass(faultClass));
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [33:0] g, input logic [33:0] e);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One channel request; a spare cycle keeps requests apart
  task automatic xfer(input logic w, input logic [7:0] s,
                      input logic [31:0] d, input logic [15:0] i = 16'h18);
    req = '{1'b1, w, i, s, d};
    @(posedge clk);
    #1;
    req.valid = 1'b0;
    got = {rsp.valid, rsp.error, rsp.data};
    @(posedge clk);
    #1;
  endtask
  task automatic readAll(input fpm_params_t e);
    for (int k = 0; k < 4; k++) begin
      xfer(1'b0, SUB_MAP_OUT + 8'(k), 32'h0);
      cmp(got, {2'b10, e[96-32*k +: 32]});
    end
  endtask
  task automatic outChk(input logic [31:0] m);
    xfer(1'b1, SUB_MAP_OUT, m);
    u_master.sendWords(m ^ 32'h5a5a_0f0f);
    cmp(m != MAP_NONE ? {1'b0, objWrite.valid, objWrite.subindex,
      objWrite.index} : {33'h0, objWrite.valid}, {1'b0, m != 0, m});
    if (m != MAP_NONE)
      cmp(34'(objWrite.data), 34'(m ^ 32'h5a5a_0f0f));
  endtask
  // Hang guard, far above the roughly 125 cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    #1;
    rst = 1'b0;
    readAll({RST_MAP_OUT, RST_MAP_IN, RST_REFRESH, RST_CLEAR});
    xfer(1'b1, SUB_MAP_OUT, 32'h1234_5678);
    cmp(got, {2'b11, ERR_RANGE});
    xfer(1'b1, SUB_MAP_IN, MAP_ACCEL);
    cmp(got, {2'b11, ERR_RANGE});
    xfer(1'b1, SUB_REFRESH, 32'h0000_ea61);
    cmp(got, {2'b11, ERR_RANGE});
    xfer(1'b1, SUB_CLEAR, 32'h2);
    cmp(got, {2'b11, ERR_RANGE});
    xfer(1'b0, SUB_CLEAR, 32'h0, 16'h0019);
    cmp(got, {2'b11, ERR_NO_OBJ});
    xfer(1'b0, 8'h06, 32'h0);
    cmp(got, {2'b11, ERR_NO_SUB});
    readAll({RST_MAP_OUT, RST_MAP_IN, RST_REFRESH, RST_CLEAR});
    outChk(MAP_ACCEL);
    outChk(MAP_DIGIO);
    outChk(MAP_NONE);
    for (int k = 0; k < 5; k++) begin
      xfer(1'b1, SUB_MAP_IN, IN_CODE[k]);
      cmp(34'(txWords), 34'(src[128-32*k +: 32]));
    end
    xfer(1'b1, SUB_MAP_IN, MAP_NONE);
    cmp(34'(txWords), 34'h0);
    xfer(1'b1, SUB_REFRESH, REFRESH_MAX);
    cmp(got, {2'b10, REFRESH_MAX});
    xfer(1'b1, SUB_REFRESH, 32'h2);
    readPending = 1'b1;
    // First pulse and the one after it, each a full period apart
    for (int p = 0; p < 2; p++) begin
      n = 0;
      do begin
        @(posedge clk);
        #1;
        n++;
      end while (readRefresh !== 1'b1 && n < 50);
      cmp(34'(n), 34'(2 * MS));
    end
    readPending = 1'b0;
    ampEnabled = 1'b1;
    for (int k = 1; k >= 0; k--) begin
      xfer(1'b1, SUB_CLEAR, 32'(k));
      u_master.setClear(1'b1);
      @(posedge clk);
      #1;
      cmp({31'h0, faultReq, faultClass}, {31'h0, k[0], CLEAR_CLASS});
      u_master.setClear(1'b0);
    end
    // Saved image brought back as after a power cycle
    img = '{MAP_DIGIO, MAP_SUPPLY, 32'h7, 32'h0};
    restore = 1'b1;
    @(posedge clk);
    #1;
    restore = 1'b0;
    cmp(34'(params.input_object_mapping), 34'(MAP_SUPPLY));
    readAll(img);
    // Restart in mid-run: defaults return, master rewrites its setting
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    readAll({RST_MAP_OUT, RST_MAP_IN, RST_REFRESH, RST_CLEAR});
    xfer(1'b1, SUB_MAP_IN, MAP_SUPPLY);
    readAll({RST_MAP_OUT, MAP_SUPPLY, RST_REFRESH, RST_CLEAR});
    give_verdict();
  end
endmodule
`default_nettype wire
